// ---- core/tlsa_top.sv ----
// torque limit selection, limiting flag and alarm handling with avalon registers
// Functional notes
// - both selects off: forward param for positive torque, reverse param for negative.
// - external select only: analog level both ways when below direction params.
// - internal select only: second internal limit both ways when below direction params.
// - both selects on: lower of analog level and second limit both ways.
// - direction param smaller than selected limit wins for that direction.
// - limiting flag high while torque reaches the applied limit.
// - any alarm drops the power stage enable at once.
// - alarm clears on reset input rising edge or control power cycle.
// - reset request ignored while alarm cause persists; alarm stays latched.
// - undervoltage alarm after control power failure lasting 60 ms.
// - any alarm invalidates home position; home return needed afterwards.
// - encoder pulse period set by two parameters.
// - torque always capped at the direction parameter.
//
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tlsa_top #(
    parameter int UV_COUNT = tlsa_pkg::UV_CYCLES
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire tlsa_pkg::tlsa_select_t select_i,
    input wire logic alarm_reset_input_i,
    input wire logic servo_on_input_i,
    input wire logic control_power_fail_i,
    input wire logic [tlsa_pkg::CAUSE_W-1:0] alarm_cause_i,
    input wire logic [tlsa_pkg::LIM_W-1:0] analog_limit_level_i,
    input wire logic [tlsa_pkg::LIM_W-1:0] torque_mag_i,
    input wire logic torque_neg_i,
    input wire logic home_done_i,
    output tlsa_pkg::tlsa_limits_t applied_limit_o,
    output logic torque_limited_flag_o,
    output logic power_stage_en_o,
    output logic alarm_o,
    output logic undervoltage_alarm_o,
    output logic home_valid_o,
    output logic encoder_pulse_o,
    output logic irq_o
);
    import tlsa_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [LIM_W-1:0] lower(input logic [LIM_W-1:0] a,
                                               input logic [LIM_W-1:0] b);
        lower = (a < b) ? a : b;
    endfunction : lower

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                res[i*8 +: 8] = data[i*8 +: 8];
        end
        merge = res;
    endfunction : merge

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int SYN_W = CAUSE_W + 5;
    logic [SYN_W-1:0] syn1_reg;
    logic [SYN_W-1:0] syn2_reg;
    logic [SYN_W-1:0] pins;
    logic int_sel;
    logic ext_sel;
    logic rst_req;
    logic servo_on_input;
    logic pfail;
    logic [CAUSE_W-1:0] cause;
    logic rst_req_d_reg;

    assign pins = {alarm_cause_i, control_power_fail_i, servo_on_input_i,
                   alarm_reset_input_i, select_i.internal_limit_select,
                   select_i.external_limit_select};

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            syn1_reg <= '0;
            syn2_reg <= '0;
        end
        else
        begin
            syn1_reg <= pins;
            syn2_reg <= syn1_reg;
        end
    end

    // active-high pins: on is one, off is zero
    assign ext_sel = syn2_reg[0];
    assign int_sel = syn2_reg[1];
    assign rst_req = syn2_reg[2];
    assign servo_on_input = syn2_reg[3];
    assign pfail = syn2_reg[4];
    assign cause = syn2_reg[SYN_W-1:5];

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rst_req_d_reg <= 1'b0;
        else
            rst_req_d_reg <= rst_req;
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    logic [LIM_W-1:0] fwd_reg;
    logic [LIM_W-1:0] rev_reg;
    logic [LIM_W-1:0] second_reg;
    logic [15:0] enc_a_reg;
    logic [15:0] enc_b_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clr;
    logic wr_acc;
    logic rd_cap;

    // a request is answered one cycle after it is first seen
    assign rd_cap = (avs_read_i || avs_write_i) && avs_waitrequest_o;
    assign wr_acc = avs_write_i && !avs_waitrequest_o;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            avs_waitrequest_o <= 1'b1;
        else
            avs_waitrequest_o <= !rd_cap;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            fwd_reg <= RST_FWD_LIMIT;
            rev_reg <= RST_REV_LIMIT;
            second_reg <= RST_SECOND_LIMIT;
            enc_a_reg <= RST_ENC_PARAM;
            enc_b_reg <= RST_ENC_PARAM;
            irq_mask_reg <= RST_IRQ_MASK;
        end
        else if (wr_acc)
        begin
            case (avs_address_i)
                OFS_FWD_LIMIT:
                    fwd_reg <= 16'(merge({16'h0000, fwd_reg}, avs_writedata_i,
                                         avs_byteenable_i));
                OFS_REV_LIMIT:
                    rev_reg <= 16'(merge({16'h0000, rev_reg}, avs_writedata_i,
                                         avs_byteenable_i));
                OFS_SECOND_LIMIT:
                    second_reg <= 16'(merge({16'h0000, second_reg}, avs_writedata_i,
                                            avs_byteenable_i));
                OFS_ENC_PARAM_A:
                    enc_a_reg <= 16'(merge({16'h0000, enc_a_reg}, avs_writedata_i,
                                           avs_byteenable_i));
                OFS_ENC_PARAM_B:
                    enc_b_reg <= 16'(merge({16'h0000, enc_b_reg}, avs_writedata_i,
                                           avs_byteenable_i));
                OFS_IRQ_MASK:
                    if (avs_byteenable_i[0])
                        irq_mask_reg <= avs_writedata_i[IRQ_W-1:0];
                default:
                    ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // limit selection, re-evaluated every cycle
    // ------------------------------------------------------------
    tlsa_mode_t mode;
    logic [LIM_W-1:0] sel_lim;
    tlsa_limits_t lim_next;

    always_comb
    begin
        case ({int_sel, ext_sel})
            2'b01: mode = TLSA_SEL_ANALOG;
            2'b10: mode = TLSA_SEL_SECOND;
            2'b11: mode = TLSA_SEL_LOWER;
            default: mode = TLSA_SEL_PARAM;
        endcase
    end

    always_comb
    begin
        sel_lim = {LIM_W{1'b1}};
        case (mode)
            TLSA_SEL_PARAM: sel_lim = {LIM_W{1'b1}};
            TLSA_SEL_ANALOG: sel_lim = analog_limit_level_i;
            TLSA_SEL_SECOND: sel_lim = second_reg;
            TLSA_SEL_LOWER: sel_lim = lower(analog_limit_level_i, second_reg);
            default: sel_lim = {LIM_W{1'b1}};
        endcase
        // direction params cap whatever was selected
        lim_next.fwd = lower(fwd_reg, sel_lim);
        lim_next.rev = lower(rev_reg, sel_lim);
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            applied_limit_o <= '0;
        else
            applied_limit_o <= lim_next;
    end

    // positive torque: forward driving or reverse regeneration
    logic tlim_next;
    assign tlim_next = torque_neg_i ? (torque_mag_i >= applied_limit_o.rev)
                                    : (torque_mag_i >= applied_limit_o.fwd);

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            torque_limited_flag_o <= 1'b0;
        else
            torque_limited_flag_o <= tlim_next;
    end

    // ------------------------------------------------------------
    // undervoltage timer
    // ------------------------------------------------------------
    logic [31:0] uv_cnt_reg;
    logic uv_cond;

    // full power loss resets the whole block, so only partial dips count here
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            uv_cnt_reg <= 32'h0000_0000;
        else if (!pfail)
            uv_cnt_reg <= 32'h0000_0000;
        else if (uv_cnt_reg < 32'(UV_COUNT))
            uv_cnt_reg <= uv_cnt_reg + 32'h0000_0001;
    end

    assign uv_cond = (uv_cnt_reg >= 32'(UV_COUNT));

    // ------------------------------------------------------------
    // alarm latch
    // ------------------------------------------------------------
    logic cond_now;
    logic rst_edge;
    logic alarm_next;
    logic uv_next;

    assign cond_now = (|cause) || uv_cond;
    assign rst_edge = rst_req && !rst_req_d_reg;

    // a present cause always wins over a reset request
    always_comb
    begin
        alarm_next = alarm_o;
        uv_next = undervoltage_alarm_o;
        if (rst_edge && !cond_now)
        begin
            alarm_next = 1'b0;
            uv_next = 1'b0;
        end
        if (cond_now)
            alarm_next = 1'b1;
        if (uv_cond)
            uv_next = 1'b1;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            alarm_o <= 1'b0;
            undervoltage_alarm_o <= 1'b0;
        end
        else
        begin
            alarm_o <= alarm_next;
            undervoltage_alarm_o <= uv_next;
        end
    end

    // drive dies in the same cycle the alarm latches
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            power_stage_en_o <= 1'b0;
        else
            power_stage_en_o <= servo_on_input && !alarm_next;
    end

    // ------------------------------------------------------------
    // home position validity
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            home_valid_o <= 1'b0;
        else if (alarm_next)
            home_valid_o <= 1'b0;
        else if (home_done_i)
            home_valid_o <= 1'b1;
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    assign irq_event[IRQ_ALARM] = alarm_next && !alarm_o;
    assign irq_event[IRQ_TLIM] = tlim_next && !torque_limited_flag_o;
    assign irq_event[IRQ_UV] = uv_next && !undervoltage_alarm_o;
    assign irq_clr = (wr_acc && avs_address_i == OFS_IRQ_STATUS && avs_byteenable_i[0])
                     ? avs_writedata_i[IRQ_W-1:0] : '0;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            irq_stat_reg <= '0;
        else
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_event;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(((irq_stat_reg & ~irq_clr) | irq_event) & irq_mask_reg);
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [31:0] status_word;

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[ST_ALARM] = alarm_o;
        status_word[ST_UV] = undervoltage_alarm_o;
        status_word[ST_TLIM] = torque_limited_flag_o;
        status_word[ST_POWER] = power_stage_en_o;
        status_word[ST_HOME] = home_valid_o;
        status_word[ST_CAUSE +: CAUSE_W] = cause;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            avs_readdata_o <= 32'h0000_0000;
        else if (rd_cap)
        begin
            case (avs_address_i)
                OFS_FWD_LIMIT: avs_readdata_o <= {16'h0000, fwd_reg};
                OFS_REV_LIMIT: avs_readdata_o <= {16'h0000, rev_reg};
                OFS_SECOND_LIMIT: avs_readdata_o <= {16'h0000, second_reg};
                OFS_ENC_PARAM_A: avs_readdata_o <= {16'h0000, enc_a_reg};
                OFS_ENC_PARAM_B: avs_readdata_o <= {16'h0000, enc_b_reg};
                OFS_STATUS: avs_readdata_o <= status_word;
                OFS_IRQ_STATUS: avs_readdata_o <= {29'h0000_0000, irq_stat_reg};
                OFS_IRQ_MASK: avs_readdata_o <= {29'h0000_0000, irq_mask_reg};
                OFS_APPLIED: avs_readdata_o <= applied_limit_o;
                default: avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // encoder pulse output
    // ------------------------------------------------------------
    tlsa_pulse_div u_pulse (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .enable_i(power_stage_en_o),
        .encoder_pulse_param_a_i(enc_a_reg),
        .encoder_pulse_param_b_i(enc_b_reg),
        .pulse_o(encoder_pulse_o)
    );
endmodule : tlsa_top
`default_nettype wire

// ---- core/tlsa_pkg.sv ----
// shared constants and types for the torque limit select and alarm block
package tlsa_pkg;
    // ------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------
    localparam int LIM_W = 16;
    localparam int CAUSE_W = 8;
    localparam int CLK_HZ = 100_000_000;
    localparam int UV_TIME_MS = 60;
    localparam int UV_CYCLES = (CLK_HZ / 1000) * UV_TIME_MS;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [5:0] OFS_FWD_LIMIT = 6'h00;
    localparam logic [5:0] OFS_REV_LIMIT = 6'h04;
    localparam logic [5:0] OFS_SECOND_LIMIT = 6'h08;
    localparam logic [5:0] OFS_ENC_PARAM_A = 6'h0C;
    localparam logic [5:0] OFS_ENC_PARAM_B = 6'h10;
    localparam logic [5:0] OFS_STATUS = 6'h14;
    localparam logic [5:0] OFS_IRQ_STATUS = 6'h18;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h1C;
    localparam logic [5:0] OFS_APPLIED = 6'h20;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_FWD_LIMIT = 16'hFFFF;
    localparam logic [15:0] RST_REV_LIMIT = 16'hFFFF;
    localparam logic [15:0] RST_SECOND_LIMIT = 16'hFFFF;
    localparam logic [15:0] RST_ENC_PARAM = 16'h0001;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_TLIM = 1;
    localparam int IRQ_UV = 2;
    localparam int IRQ_W = 3;
    localparam int ST_ALARM = 0;
    localparam int ST_UV = 1;
    localparam int ST_TLIM = 2;
    localparam int ST_POWER = 3;
    localparam int ST_HOME = 4;
    localparam int ST_CAUSE = 8;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [LIM_W-1:0] fwd;
        logic [LIM_W-1:0] rev;
    } tlsa_limits_t;

    typedef struct packed {
        logic internal_limit_select;
        logic external_limit_select;
    } tlsa_select_t;

    typedef enum logic [1:0] {
        TLSA_SEL_PARAM,
        TLSA_SEL_ANALOG,
        TLSA_SEL_SECOND,
        TLSA_SEL_LOWER
    } tlsa_mode_t;
endpackage : tlsa_pkg

// ---- core/tlsa_pulse_div.sv ----
// encoder output pulse train divider
`timescale 1ns/1ps
`default_nettype none
module tlsa_pulse_div (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic enable_i,
    input wire logic [15:0] encoder_pulse_param_a_i,
    input wire logic [15:0] encoder_pulse_param_b_i,
    output logic pulse_o
);
    import tlsa_pkg::*;
    // ------------------------------------------------------------
    // half period is a times b cycles; zero counts as one
    // ------------------------------------------------------------
    logic [31:0] half_reg;
    logic [31:0] cnt_reg;
    logic [15:0] mul_a;
    logic [15:0] mul_b;

    assign mul_a = (encoder_pulse_param_a_i == 16'h0000) ? 16'h0001 : encoder_pulse_param_a_i;
    assign mul_b = (encoder_pulse_param_b_i == 16'h0000) ? 16'h0001 : encoder_pulse_param_b_i;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            half_reg <= 32'h0000_0001;
        else
            half_reg <= {16'h0000, mul_a} * {16'h0000, mul_b};
    end

    // period change takes effect one cycle later, mid-count; a smaller value can end the current count early
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_reg <= 32'h0000_0000;
            pulse_o <= 1'b0;
        end
        else if (!enable_i)
        begin
            cnt_reg <= 32'h0000_0000;
            pulse_o <= 1'b0;
        end
        else if (cnt_reg >= half_reg - 32'h0000_0001)
        begin
            cnt_reg <= 32'h0000_0000;
            pulse_o <= ~pulse_o;
        end
        else
            cnt_reg <= cnt_reg + 32'h0000_0001;
    end
endmodule : tlsa_pulse_div
`default_nettype wire

// ---- test/tlsa_chk.sv ----
// port-level assertions for the torque limit select block
`timescale 1ns/1ps
`default_nettype none
module tlsa_chk #(
    parameter int UV_COUNT = 20
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire tlsa_pkg::tlsa_select_t select_i,
    input wire logic alarm_reset_input_i,
    input wire logic control_power_fail_i,
    input wire logic [7:0] alarm_cause_i,
    input wire logic [15:0] analog_limit_level_i,
    input wire logic [15:0] torque_mag_i,
    input wire logic torque_neg_i,
    input wire tlsa_pkg::tlsa_limits_t applied_limit_o,
    input wire logic torque_limited_flag_o,
    input wire logic power_stage_en_o,
    input wire logic alarm_o,
    input wire logic undervoltage_alarm_o,
    input wire logic home_valid_o
);
    import tlsa_pkg::*;
    // ----
    // run counters
    // ----
    localparam int UV_MAX = UV_COUNT + 8;
    logic [2:0] ext_cnt;
    int fail_cnt;
    // select run must outlast the 2 sync stages
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            ext_cnt <= 3'h0;
        else
            ext_cnt <= !select_i.external_limit_select ? 3'h0 : ext_cnt + {2'h0, ext_cnt != 3'h7};
    end
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            fail_cnt <= 0;
        else
            fail_cnt <= !control_power_fail_i ? 0 : fail_cnt + (fail_cnt <= UV_MAX);
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    ext_limit_a: assert property (
        ext_cnt >= 3'h5 |-> applied_limit_o.fwd <= $past(analog_limit_level_i)
        && applied_limit_o.rev <= $past(analog_limit_level_i))
        else $error("applied limit above analog level");
    tlim_flag_a: assert property (
        $past(arst_n_i) |-> torque_limited_flag_o == $past(torque_neg_i ?
        torque_mag_i >= applied_limit_o.rev : torque_mag_i >= applied_limit_o.fwd))
        else $error("limiting flag wrong");
    power_off_a: assert property (alarm_o |-> !power_stage_en_o)
        else $error("power stage on during alarm");
    home_lost_a: assert property ($rose(alarm_o) |-> !home_valid_o)
        else $error("home kept over alarm");
    reset_hold_a: assert property (alarm_o && $past(alarm_cause_i) != 8'h00 |=> alarm_o)
        else $error("alarm cleared with cause present");
    reset_edge_a: assert property (
        $fell(alarm_o) |-> $past(alarm_reset_input_i, 3) && !$past(alarm_reset_input_i, 4))
        else $error("alarm cleared without reset edge");
    uv_early_a: assert property ($rose(undervoltage_alarm_o) |-> fail_cnt >= UV_COUNT)
        else $error("undervoltage too early");
    uv_late_a: assert property (fail_cnt >= UV_MAX |-> undervoltage_alarm_o)
        else $error("undervoltage missing");
endmodule : tlsa_chk
bind tlsa_top tlsa_chk #(.UV_COUNT(UV_COUNT)) u_tlsa_chk (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .select_i(select_i),
    .alarm_reset_input_i(alarm_reset_input_i), .control_power_fail_i(control_power_fail_i),
    .alarm_cause_i(alarm_cause_i), .analog_limit_level_i(analog_limit_level_i),
    .torque_mag_i(torque_mag_i), .torque_neg_i(torque_neg_i),
    .applied_limit_o(applied_limit_o), .torque_limited_flag_o(torque_limited_flag_o),
    .power_stage_en_o(power_stage_en_o), .alarm_o(alarm_o),
    .undervoltage_alarm_o(undervoltage_alarm_o), .home_valid_o(home_valid_o));
`default_nettype wire

// ---- test/tlsa_ctrl_model.sv ----
// controller model driving servo on and alarm reset pins
`timescale 1ns/1ps
`default_nettype none
module tlsa_ctrl_model (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic alarm_i,
    input wire logic reset_req_i,
    output logic servo_on_o,
    output logic alarm_reset_o
);
    logic [2:0] hold_cnt;
    // ----
    // servo on and reset pin
    // ----
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            servo_on_o <= 1'b0;
        else
            servo_on_o <= !alarm_i;
    end
    // pin held 6 cycles so the sync stages see one clean edge
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            hold_cnt <= 3'h0;
        else
            hold_cnt <= reset_req_i ? 3'h6 : hold_cnt - {2'h0, hold_cnt != 3'h0};
    end
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            alarm_reset_o <= 1'b0;
        else
            alarm_reset_o <= hold_cnt != 3'h0;
    end
endmodule : tlsa_ctrl_model
`default_nettype wire

// ---- test/tlsa_tb_top.sv ----
// self-checking bench for the torque limit select block
`timescale 1ns/1ps
`default_nettype none
module tlsa_tb_top;
    import tlsa_pkg::*;
    localparam int UV_N = 20;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, q;
    tlsa_select_t sel = '0;
    logic reset_req = 1'b0, pfail = 1'b0, tneg = 1'b0, hdone = 1'b0;
    logic [7:0] cause = 8'h00;
    logic [15:0] analog = 16'h0, tmag = 16'h0;
    tlsa_limits_t applied;
    logic waitreq, res_pin, servo_on_input, tlim, pse, alarm, uv, hvalid, enc, irq, e0;
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 32'h838b;
    int pf, pr, ps, an, lim, ef, er, tq, n;
    always #5 clk_i = ~clk_i;
    tlsa_top #(.UV_COUNT(UV_N)) u_tlsa_top (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .select_i(sel), .alarm_reset_input_i(res_pin), .servo_on_input_i(servo_on_input),
        .control_power_fail_i(pfail), .alarm_cause_i(cause), .analog_limit_level_i(analog),
        .torque_mag_i(tmag), .torque_neg_i(tneg), .home_done_i(hdone),
        .applied_limit_o(applied), .torque_limited_flag_o(tlim), .power_stage_en_o(pse),
        .alarm_o(alarm), .undervoltage_alarm_o(uv), .home_valid_o(hvalid),
        .encoder_pulse_o(enc), .irq_o(irq));
    tlsa_ctrl_model u_tlsa_ctrl_model (.clk_i(clk_i), .arst_n_i(arst_n_i), .alarm_i(alarm),
        .reset_req_i(reset_req), .servo_on_o(servo_on_input), .alarm_reset_o(res_pin));
    // ----
    // tasks
    // ----
    task automatic complete_run;
        if (error_cnt == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] e, input logic [31:0] s, input string nm);
        n_tests++;
        if (e !== s)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, s);
            error_cnt++;
        end
    endtask : chk
    // request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (waitreq !== 1'b0 && k < 20);
        if (k >= 20)
            error_cnt++;
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic pulse_reset;
        reset_req <= 1'b1;
        @(posedge clk_i);
        reset_req <= 1'b0;
        repeat (12) @(posedge clk_i);
    endtask : pulse_reset
    // ----
    // main sequence
    // ----
    initial
    begin
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        bus(1'b0, OFS_SECOND_LIMIT, 32'h0);
        chk(32'h0000FFFF, q, "second limit reset");
        bus(1'b0, 6'h24, 32'h0);
        chk(32'h0, q, "unmapped read");
        for (int i = 0; i < 16; i++)
        begin
            pf = $random(seed) & 32'hFFFF;
            pr = $random(seed) & 32'hFFFF;
            ps = $random(seed) & 32'hFFFF;
            an = $random(seed) & 32'hFFFF;
            tq = $random(seed) & 32'hFFFF;
            bus(1'b1, OFS_FWD_LIMIT, pf);
            bus(1'b1, OFS_REV_LIMIT, pr);
            bus(1'b1, OFS_SECOND_LIMIT, ps);
            analog <= an[15:0];
            sel <= i[1:0];
            tmag <= tq[15:0];
            tneg <= i[2];
            repeat (5) @(posedge clk_i);
            lim = i % 4 == 1 ? an : i % 4 == 2 ? ps : i % 4 == 3 ? (an < ps ? an : ps) : 'h10000;
            ef = pf < lim ? pf : lim;
            er = pr < lim ? pr : lim;
            chk({ef[15:0], er[15:0]}, applied, "applied limit");
            chk(i[2] ? tq >= er : tq >= ef, tlim, "limiting flag");
            bus(1'b0, OFS_APPLIED, 32'h0);
            chk({ef[15:0], er[15:0]}, q, "applied register");
        end
        hdone <= 1'b1;
        @(posedge clk_i);
        hdone <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(1'b1, hvalid, "homed");
        bus(1'b1, OFS_IRQ_STATUS, 32'h7);
        bus(1'b1, OFS_IRQ_MASK, 32'h1);
        cause <= 8'h01;
        repeat (5) @(posedge clk_i);
        chk(3'b100, {alarm, pse, hvalid}, "alarm outputs");
        chk(1'b1, irq, "irq raised");
        bus(1'b1, OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk_i);
        chk(1'b0, irq, "irq masked");
        bus(1'b1, OFS_IRQ_MASK, 32'h1);
        pulse_reset();
        chk(1'b1, alarm, "alarm held");
        cause <= 8'h00;
        repeat (4) @(posedge clk_i);
        pulse_reset();
        chk(2'b00, {alarm, hvalid}, "alarm cleared");
        chk(1'b1, irq, "irq sticky");
        bus(1'b1, OFS_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(1'b0, irq, "irq cleared");
        bus(1'b1, OFS_ENC_PARAM_A, 32'h2);
        bus(1'b1, OFS_ENC_PARAM_B, 32'h3);
        // first gap may be cut short by the parameter change
        for (int j = 0; j < 3; j++)
        begin
            n = 0;
            e0 = enc;
            do
            begin
                @(posedge clk_i);
                n++;
            end
            while (enc === e0 && n < 100);
        end
        chk(6, n, "encoder half period");
        pfail <= 1'b1;
        repeat (UV_N - 4) @(posedge clk_i);
        pfail <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(1'b0, uv, "short dip");
        pfail <= 1'b1;
        repeat (UV_N + 10) @(posedge clk_i);
        chk(2'b11, {uv, alarm}, "undervoltage");
        pfail <= 1'b0;
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(2'b00, {uv, alarm}, "power cycle");
        complete_run();
    end
    initial
    begin
        #100000;
        error_cnt++;
        complete_run();
    end
endmodule : tlsa_tb_top
`default_nettype wire
